// ===== core/tsfu_fault_unit.sv
`timescale 1ns/100ps
module tsfu_fault_unit #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic switchStart,
  input wire logic switchEnd,
  input wire logic taskRegLoaded,
  input wire logic switchLinksBack,
  input wire logic backLinkWritten,
  input wire logic chkValid,
  input wire logic [3:0] chkKind,
  input wire logic [15:0] chkSelector,
  input wire logic chkBeyondLimit,
  input wire logic chkPresent,
  input wire logic chkTypeOk,
  input wire logic chkWritable,
  input wire logic chkReadable,
  input wire logic chkExecutable,
  input wire logic chkConforming,
  input wire logic chkIsStack,
  input wire logic [1:0] chkDpl,
  input wire logic tss32,
  input wire logic [31:0] tssLimit,
  input wire logic [1:0] current_privilege_level,
  input wire logic extEvent,
  input wire logic idtRef,
  input wire logic [7:0] idtVector,
  input wire logic deliverDone,
  output logic loadAllow,
  output logic switchAbort,
  output logic committed,
  output logic faultValid,
  output logic [7:0] faultVector,
  output logic [15:0] errorCode,
  output logic [1:0] savedIp,
  output logic faultNewTask,
  output logic faultContributory,
  output logic doubleFault
);

  // Register decode needs at least the four word offsets of the map
  if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32) begin : g_width_check
    $error("tsfu_fault_unit: ADDR_WIDTH out of range");
  end

  localparam int EC_INDEX_LSB = tsfu_pkg::EC_INDEX_LSB;
  localparam int EC_TI_BIT = tsfu_pkg::EC_TI_BIT;
  localparam int SEL_TI_BIT = tsfu_pkg::SEL_TI_BIT;

  function automatic logic [15:0] make_code(
    input logic [15:0] sel,
    input logic external_event_flag,
    input logic interrupt_descriptor_table_flag,
    input logic [7:0] vec
  );
    logic [15:0] code;
    code = 16'h0000;
    if (interrupt_descriptor_table_flag) begin
      code[EC_INDEX_LSB +: 8] = vec;
    end else begin
      code[15:EC_INDEX_LSB] = sel[15:EC_INDEX_LSB];
      code[EC_TI_BIT] = sel[SEL_TI_BIT];
    end
    code[tsfu_pkg::EC_EXT_BIT] = external_event_flag;
    code[tsfu_pkg::EC_IDT_BIT] = interrupt_descriptor_table_flag;
    return code;
  endfunction : make_code

  tsfu_pkg::tsfu_sw_type swState;
  tsfu_pkg::tsfu_sw_type next_swState;
  tsfu_pkg::tsfu_kind_type kind;
  logic enable;
  logic pending;
  logic [7:0] pendVec;
  logic [15:0] pendCode;
  logic delivering;
  logic [15:0] faultCount;
  logic hit;
  logic [7:0] hitVec;
  logic checkOn;
  logic commitNow;
  logic deliverNow;
  logic [7:0] deliverVec;
  logic [15:0] deliverCode;
  tsfu_pkg::tsfu_ip_type deliverIp;
  logic deliverNew;
  logic escalate;
  logic [15:0] hitCode;

  assign kind = tsfu_pkg::tsfu_kind_type'(chkKind);

  ////////////////////////////////////////////////////////////////////////////
  // Fault detection

  // After a fault behind the commit point the rest loads unchecked
  assign checkOn = enable && chkValid &&
    !(swState == tsfu_pkg::SW_POST && pending);

  always_comb begin
    hitVec = tsfu_pkg::VEC_NONE;
    unique case (kind)
      tsfu_pkg::KIND_TSS_LIMIT: begin
        if (tss32 ? tssLimit < tsfu_pkg::TSS32_MIN_LIMIT
                  : tssLimit < tsfu_pkg::TSS16_MIN_LIMIT) begin
          hitVec = tsfu_pkg::VEC_TASK_STATE;
        end
      end
      tsfu_pkg::KIND_LDT: begin
        if (chkBeyondLimit || !chkTypeOk || !chkPresent) begin
          hitVec = tsfu_pkg::VEC_TASK_STATE;
        end
      end
      tsfu_pkg::KIND_STACK: begin
        if (chkBeyondLimit || !chkWritable || chkDpl != current_privilege_level ||
            chkSelector[1:0] != current_privilege_level) begin
          hitVec = tsfu_pkg::VEC_TASK_STATE;
        end else if (!chkPresent) begin
          hitVec = tsfu_pkg::VEC_STACK;
        end
      end
      tsfu_pkg::KIND_CODE: begin
        if (chkBeyondLimit || !chkExecutable ||
            (!chkConforming && chkDpl != current_privilege_level) ||
            (chkConforming && chkDpl > current_privilege_level)) begin
          hitVec = tsfu_pkg::VEC_TASK_STATE;
        end else if (!chkPresent) begin
          hitVec = tsfu_pkg::VEC_ABSENT;
        end
      end
      tsfu_pkg::KIND_DATA: begin
        if (chkBeyondLimit || !chkReadable) begin
          hitVec = tsfu_pkg::VEC_TASK_STATE;
        end else if (!chkPresent) begin
          hitVec = tsfu_pkg::VEC_ABSENT;
        end
      end
      tsfu_pkg::KIND_LOAD_LOCAL_TABLE_INSTRUCTION, tsfu_pkg::KIND_LTR, tsfu_pkg::KIND_GATE: begin
        if (!chkPresent) begin
          hitVec = tsfu_pkg::VEC_ABSENT;
        end
      end
      tsfu_pkg::KIND_SEGLOAD: begin
        if (!chkPresent) begin
          hitVec = chkIsStack ? tsfu_pkg::VEC_STACK
                              : tsfu_pkg::VEC_ABSENT;
        end
      end
      default: hitVec = tsfu_pkg::VEC_NONE;
    endcase
    if (!checkOn) begin
      hitVec = tsfu_pkg::VEC_NONE;
    end
  end

  assign hit = hitVec != tsfu_pkg::VEC_NONE;
  assign hitCode = make_code(chkSelector, extEvent, idtRef, idtVector);

  ////////////////////////////////////////////////////////////////////////////
  // Task switch sequencing

  assign commitNow = taskRegLoaded &&
    (!switchLinksBack || backLinkWritten);

  always_comb begin
    next_swState = swState;
    unique case (swState)
      tsfu_pkg::SW_IDLE: begin
        if (switchStart) begin
          next_swState = tsfu_pkg::SW_PRE;
        end
      end
      tsfu_pkg::SW_PRE: begin
        if (hit || switchEnd) begin
          next_swState = tsfu_pkg::SW_IDLE;
        end else if (commitNow) begin
          next_swState = tsfu_pkg::SW_POST;
        end
      end
      tsfu_pkg::SW_POST: begin
        if (switchEnd) begin
          next_swState = tsfu_pkg::SW_IDLE;
        end
      end
      default: next_swState = tsfu_pkg::SW_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      swState <= tsfu_pkg::SW_IDLE;
    end else begin
      swState <= next_swState;
    end
  end

  assign committed = swState == tsfu_pkg::SW_POST;

  // Pre-commit faults abort before any state is written
  assign switchAbort = swState == tsfu_pkg::SW_PRE && hit;
  // Behind the commit point every register loads regardless
  assign loadAllow = committed || !hit;

  // First fault behind the commit point waits for the full load
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pending <= 1'b0;
      pendVec <= tsfu_pkg::VEC_NONE;
      pendCode <= 16'h0000;
    end else if (swState != tsfu_pkg::SW_POST || switchEnd) begin
      pending <= 1'b0;
    end else if (hit) begin
      pending <= 1'b1;
      pendVec <= hitVec;
      pendCode <= hitCode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delivery

  always_comb begin
    deliverNow = 1'b0;
    deliverVec = hitVec;
    deliverCode = hitCode;
    deliverIp = tsfu_pkg::IP_FAULTING;
    deliverNew = 1'b0;
    if (swState == tsfu_pkg::SW_POST) begin
      if (switchEnd && (pending || hit)) begin
        deliverNow = 1'b1;
        deliverNew = 1'b1;
        deliverIp = tsfu_pkg::IP_NEW_TASK;
        if (pending) begin
          deliverVec = pendVec;
          deliverCode = pendCode;
        end
      end
    end else if (hit) begin
      deliverNow = 1'b1;
      if (swState == tsfu_pkg::SW_PRE ||
          kind == tsfu_pkg::KIND_GATE) begin
        deliverIp = tsfu_pkg::IP_INVOKING;
      end
    end
  end

  // A contributory fault during delivery of another one escalates
  assign escalate = deliverNow && delivering;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      faultValid <= 1'b0;
      faultVector <= tsfu_pkg::VEC_NONE;
      errorCode <= 16'h0000;
      savedIp <= tsfu_pkg::IP_FAULTING;
      faultNewTask <= 1'b0;
      faultContributory <= 1'b0;
      doubleFault <= 1'b0;
    end else begin
      faultValid <= deliverNow;
      doubleFault <= escalate;
      if (deliverNow) begin
        faultVector <= escalate ? tsfu_pkg::VEC_DOUBLE : deliverVec;
        errorCode <= escalate ? 16'h0000 : deliverCode;
        savedIp <= deliverIp;
        faultNewTask <= deliverNew;
        faultContributory <= !escalate;
      end
    end
  end

  // Set wins over the clear from the delivery logic
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      delivering <= 1'b0;
    end else if (deliverNow) begin
      delivering <= 1'b1;
    end else if (deliverDone) begin
      delivering <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  logic [7:0] regAddr;
  logic mapped;
  logic wrAccess;
  logic [31:0] readValue;

  assign regAddr = 8'(paddr);
  assign mapped = regAddr == tsfu_pkg::ADDR_CTRL ||
    regAddr == tsfu_pkg::ADDR_STATUS ||
    regAddr == tsfu_pkg::ADDR_ERRCODE ||
    regAddr == tsfu_pkg::ADDR_COUNT;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wrAccess = psel && penable && pwrite && mapped;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      enable <= tsfu_pkg::CTRL_ENABLE_RESET;
    end else if (wrAccess && regAddr == tsfu_pkg::ADDR_CTRL) begin
      enable <= pwdata[tsfu_pkg::CTRL_ENABLE_BIT];
    end
  end

  // Counting wins over a clearing write in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      faultCount <= 16'h0000;
    end else if (deliverNow) begin
      faultCount <= faultCount + 16'h0001;
    end else if (wrAccess && regAddr == tsfu_pkg::ADDR_COUNT) begin
      faultCount <= 16'h0000;
    end
  end

  always_comb begin
    readValue = 32'h0000_0000;
    unique case (regAddr)
      tsfu_pkg::ADDR_CTRL: readValue[tsfu_pkg::CTRL_ENABLE_BIT] = enable;
      tsfu_pkg::ADDR_STATUS: begin
        readValue[0] = swState != tsfu_pkg::SW_IDLE;
        readValue[1] = committed;
        readValue[2] = pending;
        readValue[3] = delivering;
        readValue[tsfu_pkg::STATUS_VEC_LSB +: 8] = faultVector;
      end
      tsfu_pkg::ADDR_ERRCODE: readValue[15:0] = errorCode;
      tsfu_pkg::ADDR_COUNT: readValue[15:0] = faultCount;
      default: readValue = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle so it is a flop output
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= readValue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_tss_short_limit: assert property (
    checkOn && kind == tsfu_pkg::KIND_TSS_LIMIT && tss32 &&
    tssLimit < tsfu_pkg::TSS32_MIN_LIMIT && swState == tsfu_pkg::SW_PRE &&
    !delivering
    |=> faultValid && faultVector == tsfu_pkg::VEC_TASK_STATE &&
        savedIp == tsfu_pkg::IP_INVOKING && !faultNewTask)
    else $error("short task segment limit not reported");

  a_pre_abort_idle: assert property (
    switchAbort |-> !loadAllow ##1 swState == tsfu_pkg::SW_IDLE)
    else $error("pre-commit fault did not abort cleanly");

  a_commit_link: assert property (
    swState == tsfu_pkg::SW_PRE && !hit && !switchEnd && taskRegLoaded &&
    switchLinksBack && !backLinkWritten |=> swState == tsfu_pkg::SW_PRE)
    else $error("commit taken without back link");

  a_post_deferred: assert property (
    committed && hit && !pending && !switchEnd
    |=> pending && !faultValid)
    else $error("post-commit fault not held until the load ends");

  a_post_new_ip: assert property (
    committed && switchEnd && pending
    |=> faultValid && faultNewTask && savedIp == tsfu_pkg::IP_NEW_TASK)
    else $error("post-commit fault lacks new task context");

  a_skip_checks: assert property (
    committed && pending |-> !hit && loadAllow)
    else $error("checks continued after the first fault");

  a_stack_absent: assert property (
    checkOn && kind == tsfu_pkg::KIND_SEGLOAD && chkIsStack &&
    !chkPresent && swState == tsfu_pkg::SW_IDLE && !delivering
    |=> faultVector == tsfu_pkg::VEC_STACK)
    else $error("absent stack segment not a stack fault");

  a_dest_unchanged: assert property (
    swState == tsfu_pkg::SW_IDLE && checkOn && !chkPresent &&
    kind == tsfu_pkg::KIND_LOAD_LOCAL_TABLE_INSTRUCTION |-> !loadAllow)
    else $error("absent local table load was allowed");

  a_gate_invoking: assert property (
    swState == tsfu_pkg::SW_IDLE && checkOn && !chkPresent &&
    kind == tsfu_pkg::KIND_GATE && !delivering
    |=> savedIp == tsfu_pkg::IP_INVOKING &&
        faultVector == tsfu_pkg::VEC_ABSENT)
    else $error("gate fault saved the wrong pointer");

  a_code_flags: assert property (
    deliverNow && !escalate && swState == tsfu_pkg::SW_IDLE
    |=> errorCode[tsfu_pkg::EC_EXT_BIT] == $past(extEvent) &&
        errorCode[tsfu_pkg::EC_IDT_BIT] == $past(idtRef))
    else $error("error code flags misplaced");

  a_double_fault: assert property (
    deliverNow && delivering
    |=> doubleFault && faultVector == tsfu_pkg::VEC_DOUBLE &&
        errorCode == 16'h0000)
    else $error("second contributory fault not escalated");

  c_pre_abort: cover property (switchAbort);
  c_post_deliver: cover property (committed && switchEnd && pending);
  c_double: cover property (doubleFault);
  c_gate_absent: cover property (faultValid &&
    savedIp == tsfu_pkg::IP_INVOKING &&
    faultVector == tsfu_pkg::VEC_ABSENT);

endmodule : tsfu_fault_unit

// ===== core/tsfu_pkg.sv
// How it works
// - Invalid task state raises vector 10
// - Short task segment limit faults, own selector
// - Bad or absent local table faults
// - Four stack selector checks fault
// - Four code selector checks fault
// - Data selector limit or unreadable faults
// - Old context before commit, new after
// - Commit when task register and link set
// - Error code holds index and external flag
// - Saved pointer: invoking or new first
// - No change before commit, full load after
// - Load all registers, skip checks after fault
// - Absent code or data segment: vector 11
// - Absent stack segment gives stack fault
// - Absent local table: switch versus instruction
// - Absent task segment or gate: vector 11
// - Absent fault code: index and external flag
// - Table flag set for interrupt table entries
// - Absent fault saved pointer selection
// - After commit load all, no checks after a fault
// - Faulting destination register stays unmodified
// - Vectors 10 and 11 are contributory
package tsfu_pkg;

  localparam logic [7:0] VEC_DOUBLE = 8'h08;
  localparam logic [7:0] VEC_TASK_STATE = 8'h0a;
  localparam logic [7:0] VEC_ABSENT = 8'h0b;
  localparam logic [7:0] VEC_STACK = 8'h0c;
  localparam logic [7:0] VEC_NONE = 8'h00;

  localparam logic [31:0] TSS32_MIN_LIMIT = 32'h0000_0067;
  localparam logic [31:0] TSS16_MIN_LIMIT = 32'h0000_002c;

  // Error code layout
  localparam int EC_EXT_BIT = 0;
  localparam int EC_IDT_BIT = 1;
  localparam int EC_TI_BIT = 2;
  localparam int EC_INDEX_LSB = 3;
  localparam int SEL_TI_BIT = 2;

  // APB register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERRCODE = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int STATUS_VEC_LSB = 8;

  typedef enum logic [3:0] {
    KIND_TSS_LIMIT, KIND_LDT, KIND_STACK, KIND_CODE, KIND_DATA,
    KIND_LOAD_LOCAL_TABLE_INSTRUCTION, KIND_LTR, KIND_GATE, KIND_SEGLOAD
  } tsfu_kind_type;

  typedef enum logic [1:0] {
    IP_FAULTING, IP_INVOKING, IP_NEW_TASK
  } tsfu_ip_type;

  typedef enum logic [1:0] {SW_IDLE, SW_PRE, SW_POST} tsfu_sw_type;

endpackage : tsfu_pkg

// ===== dv/tsfu_core_model.sv
`timescale 1ns/100ps
module tsfu_core_model (
  input wire logic clock,
  input wire logic loadAllow,
  input wire logic switchAbort,
  output logic switchStart,
  output logic switchEnd,
  output logic taskRegLoaded,
  output logic switchLinksBack,
  output logic backLinkWritten,
  output logic chkValid,
  output logic [3:0] chkKind,
  output logic [15:0] chkSelector,
  output logic chkBeyondLimit,
  output logic chkPresent,
  output logic chkTypeOk,
  output logic chkWritable,
  output logic chkReadable,
  output logic chkExecutable,
  output logic chkConforming,
  output logic chkIsStack,
  output logic [1:0] chkDpl,
  output logic tss32,
  output logic [31:0] tssLimit,
  output logic [1:0] current_privilege_level,
  output logic extEvent,
  output logic idtRef,
  output logic [7:0] idtVector,
  output logic deliverDone
);
  logic allowSeen;
  logic abortSeen;

  // Privilege starts at zero; the privilege task moves it
  initial begin
    {switchStart, switchEnd, taskRegLoaded, deliverDone} = 4'h0;
    {switchLinksBack, backLinkWritten, chkValid} = 3'h0;
    {chkBeyondLimit, chkPresent, chkTypeOk, chkWritable} = 4'h0;
    {chkReadable, chkExecutable, chkConforming, chkIsStack} = 4'h0;
    {extEvent, idtRef, tss32} = 3'h0;
    chkKind = 4'hf;
    chkSelector = 16'h0000;
    chkDpl = 2'h0;
    current_privilege_level = 2'h0;
    tssLimit = 32'h0000_0067;
    idtVector = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic setup(input logic lb, input logic bw, input logic f32,
      input logic [31:0] lim, input logic external_event_flag, input logic [7:0] vec);
    @(posedge clock);
    switchLinksBack <= lb;
    backLinkWritten <= bw;
    tss32 <= f32;
    tssLimit <= lim;
    extEvent <= external_event_flag;
    idtRef <= (vec != 8'h00);
    idtVector <= vec;
  endtask : setup

  // One-hot: 8 start, 4 task register, 2 end, 1 delivery done
  task automatic pulse(input logic [3:0] which);
    @(posedge clock);
    {switchStart, taskRegLoaded, switchEnd, deliverDone} <= which;
    @(posedge clock);
    {switchStart, taskRegLoaded, switchEnd, deliverDone} <= 4'h0;
  endtask : pulse

  task automatic privilege(input logic [1:0] p);
    @(posedge clock);
    current_privilege_level <= p;
  endtask : privilege

  // Bad: 1 beyond limit, 2 absent, 3 unwritable or wrong type, 4 unreadable,
  // 5 not executable, 6 privilege one above, 7 same plus conforming
  task automatic check(input logic [3:0] k, input logic [15:0] s,
      input logic [2:0] bad);
    @(posedge clock);
    chkValid <= 1'b1;
    chkKind <= k;
    chkSelector <= s;
    chkBeyondLimit <= (bad == 3'h1);
    chkPresent <= (bad != 3'h2);
    chkTypeOk <= (bad != 3'h3);
    chkWritable <= (bad != 3'h3);
    chkReadable <= (bad != 3'h4);
    chkExecutable <= (bad != 3'h5);
    chkDpl <= (bad >= 3'h6) ? 2'h1 : 2'h0;
    chkConforming <= (bad == 3'h7);
    // Selector bit 15 marks a plain load into the stack register
    chkIsStack <= (k == 4'h2) || s[15];
    @(negedge clock);
    allowSeen = loadAllow;
    abortSeen = switchAbort;
    @(posedge clock);
    chkValid <= 1'b0;
    // Stale selector is not left looking valid
    chkKind <= 4'hf;
    chkSelector <= ~s;
  endtask : check
endmodule : tsfu_core_model

// ===== dv/task_state_and_presence_fault_unit_test.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  err_count++; $display("unexpected at %0t: got %h expected %h", \
  $time, got, exp); end end
module task_state_and_presence_fault_unit_test;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, faultVector, idtVector;
  logic [31:0] pwdata, prdata, tssLimit;
  logic switchStart, switchEnd, taskRegLoaded, switchLinksBack;
  logic backLinkWritten, chkValid, chkBeyondLimit, chkPresent, chkTypeOk;
  logic chkWritable, chkReadable, chkExecutable, chkConforming, chkIsStack;
  logic tss32, extEvent, idtRef, deliverDone, loadAllow, switchAbort;
  logic committed, faultValid, faultNewTask, faultContributory, doubleFault;
  logic [3:0] chkKind;
  logic [15:0] chkSelector, errorCode;
  logic [1:0] chkDpl, current_privilege_level, savedIp;
  int err_count = 0;
  int comparisons = 0;
  // Kind, bad code, vector, selector for checks after the commit point
  logic [30:0] tbl [12] = '{{4'h2, 3'h1, 8'h0a, 16'h0050},
    {4'h2, 3'h3, 8'h0a, 16'h0050}, {4'h2, 3'h6, 8'h0a, 16'h0050},
    {4'h2, 3'h0, 8'h0a, 16'h0051}, {4'h2, 3'h2, 8'h0c, 16'h0050},
    {4'h3, 3'h1, 8'h0a, 16'h0018}, {4'h3, 3'h5, 8'h0a, 16'h0018},
    {4'h3, 3'h6, 8'h0a, 16'h0018}, {4'h3, 3'h7, 8'h0a, 16'h0018},
    {4'h3, 3'h2, 8'h0b, 16'h0018}, {4'h4, 3'h1, 8'h0a, 16'h0020},
    {4'h4, 3'h4, 8'h0a, 16'h0024}};

  tsfu_fault_unit u_dut (.clock, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .switchStart, .switchEnd,
    .taskRegLoaded, .switchLinksBack, .backLinkWritten, .chkValid, .chkKind,
    .chkSelector, .chkBeyondLimit, .chkPresent, .chkTypeOk, .chkWritable,
    .chkReadable, .chkExecutable, .chkConforming, .chkIsStack, .chkDpl,
    .tss32, .tssLimit, .current_privilege_level, .extEvent, .idtRef, .idtVector, .deliverDone,
    .loadAllow, .switchAbort, .committed, .faultValid, .faultVector,
    .errorCode, .savedIp, .faultNewTask, .faultContributory, .doubleFault);
  tsfu_core_model u_core (.clock, .loadAllow, .switchAbort, .switchStart,
    .switchEnd, .taskRegLoaded, .switchLinksBack, .backLinkWritten,
    .chkValid, .chkKind, .chkSelector, .chkBeyondLimit, .chkPresent,
    .chkTypeOk, .chkWritable, .chkReadable, .chkExecutable, .chkConforming,
    .chkIsStack, .chkDpl, .tss32, .tssLimit, .current_privilege_level, .extEvent, .idtRef,
    .idtVector, .deliverDone);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] exp, input logic expErr);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      summarize();
    end
    if (!w) `CHK(prdata, exp)
    `CHK(pslverr, expErr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic expectFault(input logic [7:0] vec, input logic [15:0] ec,
      input logic [1:0] ip, input logic nt, input logic done);
    @(negedge clock);
    `CHK(faultValid, 1'b1)
    `CHK(faultVector, vec)
    `CHK(errorCode, ec)
    `CHK(doubleFault, (vec == 8'h08))
    if (vec != 8'h08) `CHK(savedIp, ip)
    if (vec != 8'h08) `CHK(faultNewTask, nt)
    if (vec != 8'h0c) `CHK(faultContributory, vec[3:1] == 3'h5)
    if (done) u_core.pulse(4'h1);
  endtask : expectFault

  task automatic noFault();
    @(negedge clock);
    `CHK(faultValid, 1'b0)
  endtask : noFault

  // Fault found after commit waits for the end of the switch
  task automatic postSwitch(input logic [30:0] e);
    u_core.setup(1'b0, 1'b0, 1'b1, 32'h0000_0067, 1'b0, 8'h00);
    u_core.pulse(4'h8);
    u_core.check(4'h0, 16'h0030, 3'h0);
    noFault();
    u_core.pulse(4'h4);
    u_core.check(e[30:27], e[15:0], e[26:24]);
    noFault();
    u_core.check(4'h3, 16'h0010, 3'h5);
    `CHK(u_core.allowSeen, 1'b1)
    noFault();
    u_core.pulse(4'h2);
    expectFault(e[23:16], {e[15:2], 2'h0}, 2'h2, 1'b1, 1'b1);
  endtask : postSwitch

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 32'h0000_0001, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h10, 32'h0000_0005, 32'h0, 1'b1);
    // Pre-commit limit faults at both formats' boundaries
    u_core.setup(1'b0, 1'b0, 1'b1, 32'h0000_0066, 1'b0, 8'h00);
    u_core.pulse(4'h8);
    u_core.check(4'h0, 16'h0028, 3'h0);
    `CHK(u_core.abortSeen, 1'b1)
    `CHK(u_core.allowSeen, 1'b0)
    expectFault(8'h0a, 16'h0028, 2'h1, 1'b0, 1'b1);
    u_core.setup(1'b0, 1'b0, 1'b0, 32'h0000_002c, 1'b1, 8'h00);
    u_core.pulse(4'h8);
    u_core.check(4'h0, 16'h0028, 3'h0);
    noFault();
    u_core.setup(1'b0, 1'b0, 1'b0, 32'h0000_002b, 1'b1, 8'h00);
    u_core.check(4'h0, 16'h002c, 3'h0);
    expectFault(8'h0a, 16'h002d, 2'h1, 1'b0, 1'b1);
    u_core.pulse(4'h8);
    u_core.check(4'h1, 16'h0040, 3'h2);
    expectFault(8'h0a, 16'h0041, 2'h1, 1'b0, 1'b1);
    u_core.pulse(4'h8);
    u_core.check(4'h1, 16'h0044, 3'h3);
    expectFault(8'h0a, 16'h0045, 2'h1, 1'b0, 1'b1);
    // Commit needs the back link when the switch links back
    u_core.setup(1'b1, 1'b0, 1'b1, 32'h0000_0067, 1'b0, 8'h00);
    u_core.pulse(4'h8);
    u_core.pulse(4'h4);
    @(negedge clock);
    `CHK(committed, 1'b0)
    u_core.setup(1'b1, 1'b1, 1'b1, 32'h0000_0067, 1'b0, 8'h00);
    u_core.pulse(4'h4);
    @(negedge clock);
    `CHK(committed, 1'b1)
    u_core.pulse(4'h2);
    @(negedge clock);
    `CHK(committed, 1'b0)
    for (int i = 0; i < 12; i++) begin
      postSwitch(tbl[i]);
    end
    // Absent outside a switch: segment load, local table, task register
    for (int k = 5; k < 9; k++) begin
      if (k == 7) continue;
      u_core.check(k[3:0], 16'h0058, 3'h2);
      `CHK(u_core.allowSeen, 1'b0)
      expectFault(8'h0b, 16'h0058, 2'h0, 1'b0, 1'b1);
    end
    u_core.check(4'h8, 16'h8060, 3'h2);
    expectFault(8'h0c, 16'h8060, 2'h0, 1'b0, 1'b1);
    u_core.setup(1'b0, 1'b0, 1'b1, 32'h0000_0067, 1'b1, 8'h21);
    u_core.check(4'h7, 16'h0070, 3'h2);
    expectFault(8'h0b, 16'h010b, 2'h1, 1'b0, 1'b1);
    apb(1'b0, 8'h08, 32'h0, 32'h0000_010b, 1'b0);
    u_core.setup(1'b0, 1'b0, 1'b1, 32'h0000_0067, 1'b0, 8'h00);
    // Second fault before delivery completes escalates
    u_core.check(4'h8, 16'h0058, 3'h2);
    expectFault(8'h0b, 16'h0058, 2'h0, 1'b0, 1'b0);
    u_core.check(4'h8, 16'h0058, 3'h2);
    expectFault(8'h08, 16'h0000, 2'h0, 1'b0, 1'b1);
    apb(1'b0, 8'h04, 32'h0, 32'h0000_0800, 1'b0);
    // Privilege one: matching descriptors pass, a lower code one faults
    u_core.privilege(2'h1);
    u_core.check(4'h2, 16'h0051, 3'h6);
    noFault();
    u_core.check(4'h3, 16'h0018, 3'h7);
    noFault();
    u_core.check(4'h3, 16'h0019, 3'h0);
    expectFault(8'h0a, 16'h0018, 2'h0, 1'b0, 1'b1);
    u_core.privilege(2'h0);
    apb(1'b1, 8'h00, 32'h0000_0000, 32'h0, 1'b0);
    u_core.check(4'h8, 16'h0058, 3'h2);
    noFault();
    apb(1'b1, 8'h00, 32'h0000_0001, 32'h0, 1'b0);
    apb(1'b0, 8'h00, 32'h0, 32'h0000_0001, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'h0000_0018, 1'b0);
    apb(1'b1, 8'h0c, 32'h0000_0000, 32'h0, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'h0000_0000, 1'b0);
    summarize();
  end

  // Hang guard
  initial begin
    #5_000_000;
    err_count++;
    summarize();
  end
endmodule : task_state_and_presence_fault_unit_test
